//--- hdl/flash_ctl_consts.svh
// Register offsets, field positions, key values, reset values and timing counts.
// Assumes it is included by bare name from every design file that needs it.
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH
`define FC_ADDR          8'hD1
`define FC_ERR_ADDR      8'hD2
`define FC_RESET         8'h00
`define FC_KEY_HI        7
`define FC_KEY_LO        4
`define FC_MAP_BIT       3
`define FC_SEL_HI        2
`define FC_SEL_LO        1
`define FC_BUSY_BIT      0
`define FC_KEY_ARM       4'h5
`define FC_KEY_GO        4'hA
`define FC_ERR_BIT       0
`define FC_PROG_NS       2000
`define FC_CLK_NS        8
`define FC_PROG_CYCLES   ((`FC_PROG_NS + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_PAGE_BYTES    64
`define FC_APP_HI        16'hFFFF
`define FC_USIG_HI       16'h01FF
`define FC_MSIG_HI       16'h027F
`define FC_FUSE_HI       16'h007F
`define FC_SEC_HI        16'h00FF
`endif

//--- hdl/flash_ctl_core.sv
// Core-side sequencer: loads the buffer, launches, waits, and reads bytes.
// Assumes the user issues one command at a time while ready is high.
`timescale 1ns/1ps
`include "flash_ctl_consts.svh"
module flash_ctl_core (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	flash_ctl_if.core                 bus,
	input  wire flash_ctl_pkg::cmd_t  cmd,
	input  wire logic [1:0]           space,
	input  wire logic [15:0]          addr,
	input  wire logic [7:0]           wdata,
	input  wire logic                 internal,
	output logic                      ready,
	output logic [7:0]                rdata,
	output logic                      irqEnable
);
	typedef struct packed {
		flash_ctl_pkg::seq_state_t st;
		logic [7:0]  wkey;
		logic        ie;
		logic [7:0]  rd;
		logic [7:0]  addr;
		logic [7:0]  wd;
		logic        wr;
		logic        rdS;
		logic        done;
		logic        xw;
		logic [15:0] xa;
		logic [7:0]  xd;
		logic        cr;
		logic [15:0] ca;
	} st_t;
	st_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		s_d.wr   = 1'b0;
		s_d.rdS  = 1'b0;
		s_d.done = 1'b0;
		s_d.xw   = 1'b0;
		s_d.cr   = 1'b0;
		case (s_q.st)
			flash_ctl_pkg::SeqIdle: begin
				case (cmd)
					flash_ctl_pkg::CmdLoad: begin
						s_d.xw = 1'b1;
						s_d.xa = addr;
						s_d.xd = wdata;
					end
					flash_ctl_pkg::CmdSetCtl: begin
						s_d.wr   = 1'b1;
						s_d.addr = `FC_ADDR;
						s_d.wd   = wdata;
					end
					flash_ctl_pkg::CmdRead: begin
						s_d.cr = 1'b1;
						s_d.ca = addr;
						s_d.st = flash_ctl_pkg::SeqDone;
					end
					flash_ctl_pkg::CmdProgram: begin
						s_d.ie   = 1'b0;
						s_d.wr   = 1'b1;
						s_d.addr = `FC_ADDR;
						s_d.wd   = {`FC_KEY_ARM, 1'b0, space, 1'b0};
						s_d.wkey = {`FC_KEY_GO, 1'b0, space, 1'b0};
						s_d.st   = flash_ctl_pkg::SeqWrite;
					end
					default: s_d.st = flash_ctl_pkg::SeqIdle;
				endcase
			end
			flash_ctl_pkg::SeqWrite: begin
				s_d.wr = 1'b1;
				s_d.wd = s_q.wkey;
				s_d.st = flash_ctl_pkg::SeqWait;
			end
			flash_ctl_pkg::SeqWait: begin
				if (!bus.coreStall) begin
					s_d.rdS  = 1'b1;
					s_d.addr = `FC_ADDR;
					s_d.st   = flash_ctl_pkg::SeqRead;
				end
			end
			flash_ctl_pkg::SeqRead: begin
				// Read data stand only in the cycle after the strobe, so wait for it.
				if (!s_q.done) begin
					s_d.done = 1'b1;
				end else if (bus.sfrRdata[`FC_BUSY_BIT]) begin
					s_d.st = flash_ctl_pkg::SeqWait;
				end else begin
					s_d.ie = 1'b1;
					s_d.st = flash_ctl_pkg::SeqIdle;
				end
			end
			flash_ctl_pkg::SeqDone: begin
				if (!s_q.done) begin
					s_d.done = 1'b1;
				end else begin
					s_d.rd = bus.codeRdata;
					s_d.st = flash_ctl_pkg::SeqIdle;
				end
			end
			default: s_d.st = flash_ctl_pkg::SeqIdle;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '{st: flash_ctl_pkg::SeqIdle, ie: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end
	assign ready          = (s_q.st == flash_ctl_pkg::SeqIdle) && !bus.coreStall;
	assign rdata          = s_q.rd;
	assign irqEnable      = s_q.ie;
	assign bus.sfrAddr    = s_q.addr;
	assign bus.sfrWdata   = s_q.wd;
	assign bus.sfrWr      = s_q.wr;
	assign bus.sfrRd      = s_q.rdS;
	assign bus.instrDone  = 1'b0;
	assign bus.xdataWr    = s_q.xw;
	assign bus.xdataAddr  = s_q.xa;
	assign bus.xdataWdata = s_q.xd;
	assign bus.codeRd     = s_q.cr;
	assign bus.codeAddr   = s_q.ca;
	assign bus.execInternal = internal;
endmodule // flash_ctl_core

//--- hdl/flash_ctl_device.sv
// Flash control register, launch key sequencer, page buffer and space mapping.
// Assumes the core drives the device modport synchronously to clk.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "flash_ctl_consts.svh"
module flash_ctl_device (
	input  wire logic   clk,
	input  wire logic   sys_rst,
	flash_ctl_if.device bus,
	output logic        progPulse,
	output logic [1:0]  progSpace,
	output logic [8:0]  progPage,
	output logic [7:0]  bufData [`FC_PAGE_BYTES],
	output logic [`FC_PAGE_BYTES-1:0] bufLoaded,
	input  wire logic [7:0] codeByte,
	input  wire logic [7:0] usigByte,
	input  wire logic [7:0] msigByte,
	input  wire logic [7:0] fuseByte,
	input  wire logic [7:0] secByte,
	output logic        dataWr,
	output logic        errFlag
);
	typedef struct packed {
		flash_ctl_pkg::prg_state_t st;
		logic [3:0]  key;
		logic        mapBuf;
		logic [1:0]  sel;
		logic        stall;
		logic [15:0] cnt;
		logic [8:0]  page;
		logic [`FC_PAGE_BYTES-1:0] loaded;
		logic [`FC_PAGE_BYTES-1:0][7:0] data;
		logic [7:0]  rdata;
		logic [7:0]  cdata;
		logic        err;
		logic        pulse;
	} st_t;
	st_t s_q, s_d;
	logic [2:0] region;
	logic       inRange;
	logic       busy;
	logic       ctlWr;
	// The key and select fields are decoded in several places, so once here.
	function automatic logic [3:0] keyOf(input logic [7:0] v);
		keyOf = v[`FC_KEY_HI:`FC_KEY_LO];
	endfunction
	function automatic logic [1:0] selOf(input logic [7:0] v);
		selOf = v[`FC_SEL_HI:`FC_SEL_LO];
	endfunction
	space_map u_map (
		.spaceSel (s_q.sel),
		.addr     (bus.codeAddr),
		.region   (region),
		.inRange  (inRange)
	);
	assign busy  = (s_q.st == flash_ctl_pkg::PrgRun);
	assign ctlWr = bus.sfrWr && (bus.sfrAddr == `FC_ADDR);
	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (ctlWr) begin
			s_d.key    = keyOf(bus.sfrWdata);
			s_d.mapBuf = bus.sfrWdata[`FC_MAP_BIT];
			s_d.sel    = selOf(bus.sfrWdata);
		end
		if (bus.sfrWr && bus.sfrAddr == `FC_ERR_ADDR && !bus.sfrWdata[`FC_ERR_BIT]) begin
			s_d.err = 1'b0;
		end
		case (s_q.st)
			flash_ctl_pkg::PrgIdle: begin
				if (ctlWr && keyOf(bus.sfrWdata) == `FC_KEY_ARM) begin
					s_d.st = flash_ctl_pkg::PrgArm;
				end
			end
			flash_ctl_pkg::PrgArm: begin
				if (ctlWr && keyOf(bus.sfrWdata) == `FC_KEY_GO
						&& selOf(bus.sfrWdata) != 2'h3) begin
					s_d.st    = flash_ctl_pkg::PrgRun;
					s_d.sel   = selOf(bus.sfrWdata);
					s_d.cnt   = 16'(`FC_PROG_CYCLES);
					s_d.stall = bus.execInternal;
					s_d.pulse = 1'b1;
				end else if (ctlWr && keyOf(bus.sfrWdata) == `FC_KEY_ARM) begin
					s_d.st = flash_ctl_pkg::PrgArm;
				end else if (ctlWr || bus.instrDone) begin
					s_d.st = flash_ctl_pkg::PrgIdle;
				end
			end
			flash_ctl_pkg::PrgRun: begin
				if (bus.brownOut) begin
					s_d.err = 1'b1;
					s_d.st  = flash_ctl_pkg::PrgDone;
				end else if (s_q.cnt <= 16'h0001) begin
					s_d.st = flash_ctl_pkg::PrgDone;
				end else begin
					s_d.cnt = s_q.cnt - 16'h0001;
				end
			end
			flash_ctl_pkg::PrgDone: begin
				s_d.loaded = '0;
				s_d.stall  = 1'b0;
				s_d.st     = flash_ctl_pkg::PrgIdle;
			end
			default: s_d.st = flash_ctl_pkg::PrgIdle;
		endcase
		if (bus.xdataWr && s_q.mapBuf && !busy) begin
			if (!s_q.loaded[bus.xdataAddr[5:0]]) begin
				s_d.data[bus.xdataAddr[5:0]]   = bus.xdataWdata;
				s_d.loaded[bus.xdataAddr[5:0]] = 1'b1;
			end
			s_d.page = bus.xdataAddr[15:7];
		end
		s_d.rdata = 8'h00;
		if (bus.sfrRd && bus.sfrAddr == `FC_ADDR) begin
			s_d.rdata = {s_q.key, s_q.mapBuf, s_q.sel, busy};
		end else if (bus.sfrRd && bus.sfrAddr == `FC_ERR_ADDR) begin
			s_d.rdata = {7'h00, s_q.err};
		end
		if (bus.codeRd) begin
			case (region)
				3'h0: s_d.cdata = codeByte;
				3'h1: s_d.cdata = usigByte;
				3'h2: s_d.cdata = msigByte;
				3'h3: s_d.cdata = fuseByte;
				3'h4: s_d.cdata = secByte;
				default: s_d.cdata = 8'hFF;
			endcase
			if (!inRange) begin
				s_d.cdata = 8'hFF;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign bus.sfrRdata  = s_q.rdata;
	assign bus.codeRdata = s_q.cdata;
	assign bus.coreStall = s_q.stall && busy;
	assign dataWr    = bus.xdataWr && !s_q.mapBuf;
	assign progPulse = s_q.pulse;
	assign progSpace = s_q.sel;
	assign progPage  = s_q.page;
	assign bufLoaded = s_q.loaded;
	assign errFlag   = s_q.err;
	generate
		for (genvar i = 0; i < `FC_PAGE_BYTES; i++) begin : g_buf
			assign bufData[i] = s_q.data[i];
		end
	endgenerate
endmodule // flash_ctl_device

//--- hdl/flash_ctl_if.sv
// Core-side bus between the processor model and the flash launch controller.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface flash_ctl_if;
	logic [7:0]  sfrAddr;
	logic [7:0]  sfrWdata;
	logic        sfrWr;
	logic        sfrRd;
	logic [7:0]  sfrRdata;
	logic        instrDone;
	logic        xdataWr;
	logic [15:0] xdataAddr;
	logic [7:0]  xdataWdata;
	logic        codeRd;
	logic [15:0] codeAddr;
	logic [7:0]  codeRdata;
	logic        execInternal;
	logic        coreStall;
	logic        brownOut;
	modport device (
		input  sfrAddr, sfrWdata, sfrWr, sfrRd, instrDone, xdataWr, xdataAddr,
		input  xdataWdata, codeRd, codeAddr, execInternal, brownOut,
		output sfrRdata, codeRdata, coreStall
	);
	modport core (
		output sfrAddr, sfrWdata, sfrWr, sfrRd, instrDone, xdataWr, xdataAddr,
		output xdataWdata, codeRd, codeAddr, execInternal,
		input  sfrRdata, codeRdata, coreStall
	);
endinterface

//--- hdl/flash_ctl_pkg.sv
// Types for the flash launch controller; each state type belongs to one end only.
// Assumes nothing beyond the constants header.
package flash_ctl_pkg;
	typedef enum logic [1:0] {
		SpaceCode = 2'h0,
		SpaceSig  = 2'h1,
		SpaceFuse = 2'h2,
		SpaceRsvd = 2'h3
	} space_t;
	typedef enum logic [2:0] {
		PrgIdle = 3'h0,
		PrgArm  = 3'h1,
		PrgRun  = 3'h3,
		PrgDone = 3'h2
	} prg_state_t;
	typedef enum logic [2:0] {
		SeqIdle  = 3'h0,
		SeqWrite = 3'h1,
		SeqRead  = 3'h3,
		SeqWait  = 3'h2,
		SeqDone  = 3'h6
	} seq_state_t;
	typedef enum logic [2:0] {
		CmdNone    = 3'h0,
		CmdProgram = 3'h1,
		CmdRead    = 3'h2,
		CmdLoad    = 3'h3,
		CmdSetCtl  = 3'h4
	} cmd_t;
endpackage

//--- hdl/space_map.sv
// Maps a program-memory read address to a space and checks it is in range.
// Assumes a combinational lookup, used by the device end.
`timescale 1ns/1ps
`include "flash_ctl_consts.svh"
module space_map (
	input  wire logic [1:0]  spaceSel,
	input  wire logic [15:0] addr,
	output logic      [2:0]  region,
	output logic             inRange
);
	always_comb begin
		region  = 3'h0;
		inRange = 1'b1;
		case (spaceSel)
			2'h0: begin
				region  = 3'h0;
				inRange = (addr <= `FC_APP_HI);
			end
			2'h1: begin
				region  = (addr <= `FC_USIG_HI) ? 3'h1 : 3'h2;
				inRange = (addr <= `FC_MSIG_HI);
			end
			2'h2: begin
				region  = (addr <= `FC_FUSE_HI) ? 3'h3 : 3'h4;
				inRange = (addr <= `FC_SEC_HI);
			end
			default: begin
				region  = 3'h7;
				inRange = 1'b0;
			end
		endcase
	end
endmodule // space_map

//--- verification/flash_ctl_checker.sv
// Checker on the bus that joins the core end to the device end.
// Assumes the testbench hands it that bus's signals by name.
`timescale 1ns/1ps
module flash_ctl_checker (
	input logic       clk,
	input logic       sys_rst,
	input logic [7:0] sfrAddr,
	input logic [7:0] sfrWdata,
	input logic       sfrWr,
	input logic       sfrRd,
	input logic [7:0] sfrRdata,
	input logic       instrDone,
	input logic       execInternal,
	input logic       coreStall,
	input logic       brownOut
);
	logic [2:0] selSeen_q;
	logic       ctlWr;
	assign ctlWr = sfrWr && sfrAddr == 8'hD1;
	always_ff @(posedge clk) begin
		if (sys_rst)
			selSeen_q <= 3'h0;
		else if (ctlWr)
			selSeen_q <= sfrWdata[3:1];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_arm;
		ctlWr && sfrWdata[7:4] == 4'h5;
	endsequence
	// A brown-out aborts the write, so launches under it are left out.
	sequence s_go;
		ctlWr && sfrWdata[7:4] == 4'hA && !instrDone && !brownOut && !coreStall;
	endsequence
	property p_launchStall;
		s_arm ##1 s_go ##0 (sfrWdata[2:1] != 2'h3 && execInternal) |=> coreStall;
	endproperty
	a_launchStall: assert property (p_launchStall) else $error("no stall");
	property p_reservedIdle;
		s_arm ##1 s_go ##0 sfrWdata[2:1] == 2'h3 |=> !coreStall [*3];
	endproperty
	a_reservedIdle: assert property (p_reservedIdle) else $error("reserved ran");
	property p_stallHolds;
		$rose(coreStall) |-> coreStall [*8];
	endproperty
	a_stallHolds: assert property (p_stallHolds) else $error("stall dropped");
	property p_stallEnds;
		$rose(coreStall) |-> ##[249:252] !coreStall;
	endproperty
	a_stallEnds: assert property (p_stallEnds) else $error("stall length");
	property p_stallCause;
		$rose(coreStall) |-> $past(ctlWr) && $past(sfrWdata[7:4]) == 4'hA;
	endproperty
	a_stallCause: assert property (p_stallCause) else $error("stall without key");
	property p_stallBusy;
		sfrRd && sfrAddr == 8'hD1 && coreStall |=> sfrRdata[0];
	endproperty
	a_stallBusy: assert property (p_stallBusy) else $error("busy low in stall");
	property p_ctlReadback;
		sfrRd && sfrAddr == 8'hD1 |=> sfrRdata[3:1] == selSeen_q;
	endproperty
	a_ctlReadback: assert property (p_ctlReadback) else $error("control readback");
	property p_unmappedZero;
		sfrRd && sfrAddr != 8'hD1 && sfrAddr != 8'hD2 |=> sfrRdata == 8'h00;
	endproperty
	a_unmappedZero: assert property (p_unmappedZero) else $error("unmapped read");
endmodule // flash_ctl_checker

//--- verification/flash_program_launch_control_tb.sv
// Testbench: both ends joined, plus a second device driven straight on its bus.
// Assumes the design files and constants header are compiled first.
`timescale 1ns/1ps
module flash_program_launch_control_tb;
	logic                clk;
	logic                sys_rst;
	flash_ctl_pkg::cmd_t cmd;
	logic [1:0]          space, progSpace, progSpace2;
	logic [15:0]         addr, pulses, pulses2, n_errors, total_checks;
	logic [7:0]          wdata, rdata, d;
	logic                internal, ready, irqEnable, progPulse, pulse2, dataWr, errFlag;
	logic [8:0]          progPage, lastPage;
	logic [7:0]          bufData [64];
	logic [63:0]         bufLoaded;
	logic                stallSeen, wrSeen;
	logic [7:0]          romCode, romUsig, romMsig, romFuse, romSec;
	flash_ctl_if bus ();
	flash_ctl_if bus2 ();
	flash_ctl_core u_flash_ctl_core (.clk(clk), .sys_rst(sys_rst), .bus(bus), .cmd(cmd),
		.space(space), .addr(addr), .wdata(wdata), .internal(internal), .ready(ready),
		.rdata(rdata), .irqEnable(irqEnable));
	flash_ctl_device u_flash_ctl_device (.clk(clk), .sys_rst(sys_rst), .bus(bus),
		.progPulse(progPulse), .progSpace(progSpace), .progPage(progPage), .bufData(bufData),
		.bufLoaded(bufLoaded), .codeByte(romCode), .usigByte(romUsig), .msigByte(romMsig),
		.fuseByte(romFuse), .secByte(romSec), .dataWr(dataWr), .errFlag(errFlag));
	// The second device lets the bench break the key sequence, which the core never does.
	flash_ctl_device u_flash_ctl_device2 (.clk(clk), .sys_rst(sys_rst), .bus(bus2),
		.progPulse(pulse2), .progSpace(progSpace2), .progPage(), .bufData(), .bufLoaded(),
		.codeByte(romCode), .usigByte(romUsig), .msigByte(romMsig), .fuseByte(romFuse),
		.secByte(romSec), .dataWr(), .errFlag());
	flash_ctl_checker u_chk (.clk(clk), .sys_rst(sys_rst), .sfrAddr(bus.sfrAddr),
		.sfrWdata(bus.sfrWdata), .sfrWr(bus.sfrWr), .sfrRd(bus.sfrRd), .sfrRdata(bus.sfrRdata),
		.instrDone(bus.instrDone), .execInternal(bus.execInternal), .coreStall(bus.coreStall),
		.brownOut(bus.brownOut));
	// Unknown levels before the first reset edge must not stick in the flags.
	always @(posedge clk) begin
		if (!sys_rst) begin
			if (progPulse) begin
				pulses++;
				lastPage = progPage;
			end
			if (pulse2)
				pulses2++;
			stallSeen |= bus.coreStall;
			wrSeen |= dataWr;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic doCmd(input flash_ctl_pkg::cmd_t c, input logic [1:0] s,
		input logic [15:0] a, input logic [7:0] w, input logic in);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		{space, addr, wdata, internal} <= {s, a, w, in};
		cmd <= c;
		@(posedge clk);
		cmd <= flash_ctl_pkg::CmdNone;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ready !== 1'b1 && n < 400);
		chk(n < 400, 1'b1, "command hang");
	endtask
	task automatic sfrW(input logic [7:0] a, input logic [7:0] w, input logic done);
		@(posedge clk);
		{bus2.sfrAddr, bus2.sfrWdata} <= {a, w};
		bus2.sfrWr <= !done;
		bus2.instrDone <= done;
		@(posedge clk);
		{bus2.sfrWr, bus2.instrDone} <= 2'b00;
	endtask
	task automatic sfrR(input logic [7:0] a);
		@(posedge clk);
		bus2.sfrAddr <= a;
		bus2.sfrRd <= 1'b1;
		@(posedge clk);
		bus2.sfrRd <= 1'b0;
		@(negedge clk);
		d = bus2.sfrRdata;
	endtask
	task automatic t_keys;
		sfrR(8'hD1);
		chk(d, 8'h00, "control reset");
		chk(irqEnable, 1'b1, "irq reset");
		sfrW(8'hD1, 8'h50, 0);
		sfrW(8'hD1, 8'h00, 1);
		sfrW(8'hD1, 8'hA0, 0);
		sfrW(8'hD1, 8'h50, 0);
		sfrW(8'hD1, 8'h30, 0);
		sfrW(8'hD1, 8'hA0, 0);
		sfrW(8'hD1, 8'h56, 0);
		sfrW(8'hD1, 8'hA6, 0);
		repeat (3) @(posedge clk);
		chk(pulses2, 16'h0, "launch not refused");
		sfrW(8'hD1, 8'h01, 0);
		sfrR(8'hD1);
		chk(d[0], 1'b0, "busy written");
		sfrW(8'hD1, 8'h52, 0);
		sfrW(8'hD1, 8'hA2, 0);
		sfrR(8'hD1);
		chk(d[0], 1'b1, "busy after launch");
		chk({pulses2[13:0], progSpace2}, {14'h1, 2'h1}, "keyed launch");
	endtask
	task automatic t_program;
		logic [15:0] first [4] = '{16'h2301, 16'h0011, 16'h0002, 16'h0003};
		logic [15:0] last [4] = '{16'hABC5, 16'h0185, 16'h0047, 16'h0004};
		logic [15:0] p;
		for (int s = 0; s < 6; s++) begin
			p = pulses;
			stallSeen = 0;
			doCmd(flash_ctl_pkg::CmdSetCtl, 2'h0, 16'h0, 8'h08, 1'b0);
			doCmd(flash_ctl_pkg::CmdLoad, s[1:0], first[s%4], 8'h3C, 1'b0);
			doCmd(flash_ctl_pkg::CmdLoad, s[1:0], last[s%4], 8'hC3, 1'b0);
			@(negedge clk);
			chk({bufData[last[s%4][5:0]], wrSeen}, 9'h186, "buffer load");
			if (s == 5) begin
				@(posedge clk);
				bus.brownOut <= 1'b1;
			end
			doCmd(flash_ctl_pkg::CmdProgram, s[1:0], 16'h0, 8'h0, s < 4);
			@(posedge clk);
			bus.brownOut <= 1'b0;
			repeat (3) @(posedge clk);
			chk(pulses, p + (s != 3), "launch count");
			chk(stallSeen, s < 3, "stall");
			chk(|bufLoaded, s == 3, "buffer cleared");
			if (s < 3)
				chk(lastPage, last[s][15:7], "target page");
		end
		chk(errFlag, 1'b1, "brown-out flag");
	endtask
	task automatic t_read;
		logic [7:0] ctl [8] = '{8'h00, 8'h02, 8'h02, 8'h04, 8'h04, 8'h04, 8'h06, 8'h00};
		logic [15:0] ra [8] = '{16'h1234, 16'h10, 16'h210, 16'h10, 16'h90, 16'h100, 16'h10,
			16'hFF};
		logic [7:0] ex [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hFF, 8'hFF, 8'h11};
		for (int i = 0; i < 8; i++) begin
			doCmd(flash_ctl_pkg::CmdSetCtl, ctl[i][2:1], 16'h0, ctl[i], 1'b0);
			doCmd(flash_ctl_pkg::CmdRead, ctl[i][2:1], ra[i], 8'h0, 1'b0);
			chk(rdata, ex[i], "mapped read");
		end
		doCmd(flash_ctl_pkg::CmdLoad, 2'h0, 16'h0010, 8'h77, 1'b0);
		@(negedge clk);
		chk({wrSeen, |bufLoaded}, 2'b10, "plain data write");
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		n_errors++;
		results;
	end
	initial begin
		{sys_rst, cmd, space, addr, wdata, internal} = {1'b1, 30'h0};
		{pulses, pulses2, n_errors, total_checks, stallSeen, wrSeen} = '0;
		bus.brownOut = 0;
		{romCode, romUsig, romMsig, romFuse, romSec} = 40'h1122334455;
		{bus2.sfrAddr, bus2.sfrWdata, bus2.sfrWr, bus2.sfrRd, bus2.instrDone} = '0;
		{bus2.xdataWr, bus2.xdataAddr, bus2.xdataWdata, bus2.codeRd, bus2.codeAddr} = '0;
		{bus2.execInternal, bus2.brownOut} = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_keys;
		t_program;
		t_read;
		results;
	end
endmodule // flash_program_launch_control_tb
